// File: cac_card.sv
`timescale 1ns/1ps
`default_nettype none
`include "cac_consts.svh"

module cac_card #(
  parameter logic [8:0] ETU_CLKS = `CAC_ETU_DEF
) (
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic              card_clk_i,
  input  wire logic              card_rst_n_i,
  input  wire logic              io_i,
  output logic                   io_o,
  output logic                   io_oe_o,
  input  wire cac_pkg::cac_cfg_t cfg_i,
  input  wire cac_pkg::cac_byte_t tx_i,
  output logic                   tx_ready_o,
  output logic                   atr_done_o,
  output logic                   cfg_err_o
);
  import cac_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic       cclk_s1_q, cclk_s2_q, cclk_s3_q;
  logic       crst_s1_q, crst_s2_q;
  logic       io_s1_q, io_s2_q;
  logic       cedge_w;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cclk_s1_q <= 1'b0;
      cclk_s2_q <= 1'b0;
      cclk_s3_q <= 1'b0;
      crst_s1_q <= 1'b0;
      crst_s2_q <= 1'b0;
      io_s1_q   <= 1'b1;
      io_s2_q   <= 1'b1;
    end else begin
      cclk_s1_q <= card_clk_i;
      cclk_s2_q <= cclk_s1_q;
      cclk_s3_q <= cclk_s2_q;
      crst_s1_q <= card_rst_n_i;
      crst_s2_q <= crst_s1_q;
      io_s1_q   <= io_i;
      io_s2_q   <= io_s1_q;
    end
  end

  // etu and delay count rising card clock edges only
  assign cedge_w = cclk_s2_q && !cclk_s3_q;

  // ----------------------------------------
  // configuration check
  // ----------------------------------------
  cac_cfg_t   cfg_q;
  logic [5:0] cls_w, run_w;
  logic       cls_ok_w, pair_ok_w;
  logic [7:0] ta1_w, ta3_w;

  // settings are taken while the card is held in reset
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cfg_q <= '0;
    end else if (!crst_s2_q) begin
      cfg_q <= cfg_i;
    end
  end

  always_comb begin
    // a legal class set is one unbroken run of ones
    cls_w     = {1'b0, cfg_q.classes};
    run_w     = cls_w | (cls_w - 6'h01);
    cls_ok_w  = (cls_w != 6'h00) && (((run_w + 6'h01) & run_w) == 6'h00);
    pair_ok_w = ((cfg_q.fi == `CAC_FI_372) && (cfg_q.di == `CAC_DI_1)) ||
                ((cfg_q.fi == `CAC_FI_512) &&
                 ((cfg_q.di == `CAC_DI_8) || (cfg_q.di == `CAC_DI_16) ||
                  (cfg_q.di == `CAC_DI_64)));
    // unsupported pairs fall back to the default factors
    ta1_w     = pair_ok_w ? {cfg_q.fi, cfg_q.di} : `CAC_TA1_DEF;
    ta3_w     = {3'b000, cfg_q.classes};
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cfg_err_o <= 1'b0;
    end else begin
      cfg_err_o <= !cls_ok_w || !pair_ok_w;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  cac_state_t  state_q;
  logic [10:0] dly_q;
  logic [3:0]  idx_q;
  logic [7:0]  tck_q;
  logic [7:0]  byte_w;
  logic        busy_q;
  logic        ld_w;

  always_comb begin
    case (idx_q)
      4'h0:    byte_w = `CAC_TS;
      4'h1:    byte_w = `CAC_T0;
      4'h2:    byte_w = ta1_w;
      4'h3:    byte_w = `CAC_TD1;
      4'h4:    byte_w = `CAC_TD2;
      4'h5:    byte_w = ta3_w;
      4'h6:    byte_w = `CAC_CAT;
      4'h7:    byte_w = `CAC_TAG_CDS;
      4'h8:    byte_w = cfg_q.cds;
      4'h9:    byte_w = `CAC_TAG_CAP;
      4'hA:    byte_w = cfg_q.caps[23:16];
      4'hB:    byte_w = cfg_q.caps[15:8];
      4'hC:    byte_w = cfg_q.caps[7:0];
      default: byte_w = tck_q;
    endcase
  end

  // a new character starts only on an idle, released line
  assign ld_w = !busy_q && io_s2_q &&
                (state_q == CAC_ATR || (state_q == CAC_APP && tx_i.valid));
  assign tx_ready_o = (state_q == CAC_APP) && !busy_q && io_s2_q;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !crst_s2_q) begin
      state_q <= CAC_IDLE;
      dly_q   <= 11'h000;
    end else begin
      case (state_q)
        CAC_IDLE: begin
          state_q <= CAC_WAIT;
          dly_q   <= 11'h000;
        end
        CAC_WAIT: begin
          if (cedge_w) begin
            dly_q <= dly_q + 11'h001;
            if (dly_q == `CAC_ATR_DELAY) begin
              state_q <= CAC_ATR;
            end
          end
        end
        CAC_ATR: begin
          if (ld_w && idx_q == `CAC_ATR_LAST) begin
            state_q <= CAC_APP;
          end
        end
        CAC_APP: state_q <= CAC_APP;
        default: state_q <= CAC_IDLE;
      endcase
    end
  end

  // check byte covers everything after the initial character
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !crst_s2_q) begin
      idx_q <= 4'h0;
      tck_q <= 8'h00;
    end else if (ld_w && state_q == CAC_ATR) begin
      idx_q <= idx_q + 4'h1;
      if (idx_q != 4'h0) begin
        tck_q <= tck_q ^ byte_w;
      end
    end
  end

  logic atr_done_q;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !crst_s2_q) begin
      atr_done_q <= 1'b0;
    end else if (state_q == CAC_APP && !busy_q) begin
      atr_done_q <= 1'b1;
    end
  end
  assign atr_done_o = atr_done_q;

  // ----------------------------------------
  // character transmitter
  // ----------------------------------------
  // factors stay at the default etu: negotiation is handled elsewhere
  logic [9:0] sh_q;
  logic [3:0] bit_q;
  logic [8:0] etu_q;
  logic       oe_q;
  logic [7:0] src_w;

  assign src_w = (state_q == CAC_ATR) ? byte_w : tx_i.data;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !crst_s2_q) begin
      busy_q <= 1'b0;
      oe_q   <= 1'b0;
      sh_q   <= 10'h3FF;
      bit_q  <= 4'h0;
      etu_q  <= 9'h000;
    end else if (ld_w) begin
      busy_q <= 1'b1;
      oe_q   <= 1'b1;
      sh_q   <= {^src_w, src_w, 1'b0};
      bit_q  <= 4'h0;
      etu_q  <= 9'h000;
    end else if (busy_q && cedge_w) begin
      if (etu_q == ETU_CLKS - 9'h001) begin
        etu_q <= 9'h000;
        sh_q  <= {1'b1, sh_q[9:1]};
        if (bit_q == `CAC_LAST_DRV) begin
          oe_q <= 1'b0;
        end
        if (bit_q == `CAC_LAST_BIT) begin
          busy_q <= 1'b0;
        end else begin
          bit_q <= bit_q + 4'h1;
        end
      end else begin
        etu_q <= etu_q + 9'h001;
      end
    end
  end

  assign io_o    = sh_q[0];
  assign io_oe_o = oe_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // aborted answers are fenced off by the card-reset disable
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i || !crst_s2_q);

  logic ld_atr_w;
  assign ld_atr_w = ld_w && state_q == CAC_ATR;

  a_tx_gate: assert property (tx_ready_o |-> state_q == CAC_APP && idx_q == 4'hE)
    else $error("byte offered before answer complete");
  a_first_byte: assert property (ld_atr_w && idx_q == 4'h0 |=> sh_q[8:1] == `CAC_TS)
    else $error("answer does not open with initial character");
  a_start_bit: assert property (ld_w |=> io_oe_o && !io_o)
    else $error("character does not open with a start bit");
  a_rel_idle: assert property (!busy_q |-> !io_oe_o)
    else $error("line driven while transmitter idle");
  a_cfg_frozen: assert property (crst_s2_q |=> $stable(cfg_q))
    else $error("settings changed while card active");
  // configuration checks also run while the card is held in reset
  a_class_adj: assert property (disable iff (!rst_n_i)
                                cfg_q.classes == 5'h05 |=> cfg_err_o)
    else $error("non adjacent classes not flagged");
  a_class_bits: assert property (ld_atr_w && idx_q == `CAC_IDX_TA3 |=>
                                 sh_q[5:1] == cfg_q.classes)
    else $error("class flags wrong");
  a_ta1_pair: assert property (ld_atr_w && idx_q == `CAC_IDX_TA1 |=>
                               !(sh_q[4:1] == `CAC_DI_64 && sh_q[8:5] != `CAC_FI_512))
    else $error("divisor 64 without rate 512");
  a_mand_pairs: assert property (disable iff (!rst_n_i)
                                 cfg_q.fi == `CAC_FI_512 && cfg_q.di == `CAC_DI_16 &&
                                 cls_ok_w |=> !cfg_err_o)
    else $error("mandatory pair refused");
  a_ta1_def: assert property (ld_atr_w && idx_q == `CAC_IDX_TA1 && !pair_ok_w |=>
                              sh_q[8:1] == `CAC_TA1_DEF)
    else $error("default factors not advertised");
  a_ta1_value: assert property (ld_atr_w && idx_q == `CAC_IDX_TA1 && pair_ok_w |=>
                                sh_q[8:1] == {cfg_q.fi, cfg_q.di})
    else $error("factor byte wrong");
  a_t15_glob: assert property (ld_atr_w && idx_q == `CAC_IDX_TD2 |=> sh_q[4:1] == 4'hF)
    else $error("type 15 indication missing");
  a_hist_cat: assert property (ld_atr_w && idx_q == `CAC_IDX_CAT |=> sh_q[8:1] == `CAC_CAT)
    else $error("category byte wrong");
  a_hist_cds: assert property (ld_atr_w && idx_q == `CAC_IDX_CDS |=>
                               sh_q[8:1] == `CAC_TAG_CDS)
    else $error("data service tag wrong");
  a_hist_cap: assert property (ld_atr_w && idx_q == `CAC_IDX_CAP |=>
                               sh_q[8:1] == `CAC_TAG_CAP)
    else $error("capabilities tag wrong");
  a_guard_rel: assert property (busy_q && bit_q > `CAC_LAST_DRV |-> !io_oe_o)
    else $error("line driven during guard time");

  c_atr_done: cover property (!atr_done_o ##1 atr_done_o);
  c_app_byte: cover property (tx_ready_o && tx_i.valid);
  c_cfg_err:  cover property (cfg_err_o);
  c_ta1_def:  cover property (ld_atr_w && idx_q == `CAC_IDX_TA1 && !pair_ok_w);
  c_atr_cut:  cover property (disable iff (!rst_n_i)
                              busy_q && state_q == CAC_ATR ##1 !crst_s2_q);
endmodule // cac_card

`default_nettype wire

// File: cac_consts.svh
`ifndef CAC_CONSTS_SVH
`define CAC_CONSTS_SVH
// ----------------------------------------
// link timing, counted in card clock edges and character bit positions
// ----------------------------------------
`define CAC_ETU_DEF    9'h174
`define CAC_ATR_DELAY  11'h3E8
`define CAC_LAST_BIT   4'hB
`define CAC_LAST_DRV   4'h9
// ----------------------------------------
// answer-to-reset bytes
// ----------------------------------------
`define CAC_TS         8'h3B
`define CAC_T0         8'h97
`define CAC_TD1        8'h80
`define CAC_TD2        8'h1F
`define CAC_CAT        8'h80
`define CAC_TAG_CDS    8'h31
`define CAC_TAG_CAP    8'h73
`define CAC_ATR_LAST   4'hD
`define CAC_IDX_TA1    4'h2
`define CAC_IDX_TD2    4'h4
`define CAC_IDX_TA3    4'h5
`define CAC_IDX_CAT    4'h6
`define CAC_IDX_CDS    4'h7
`define CAC_IDX_CAP    4'h9
// ----------------------------------------
// transmission factor codes
// ----------------------------------------
`define CAC_FI_372     4'h1
`define CAC_DI_1       4'h1
`define CAC_FI_512     4'h9
`define CAC_DI_8       4'h4
`define CAC_DI_16      4'h5
`define CAC_DI_64      4'h7
`define CAC_TA1_DEF    8'h11
`endif

// File: cac_pkg.sv
package cac_pkg;
  typedef struct packed {
    logic [4:0]  classes;
    logic [3:0]  fi;
    logic [3:0]  di;
    logic [7:0]  cds;
    logic [23:0] caps;
  } cac_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } cac_byte_t;

  typedef enum logic [1:0] {
    CAC_IDLE,
    CAC_WAIT,
    CAC_ATR,
    CAC_APP
  } cac_state_t;
endpackage

// File: cac_term_model.sv
`timescale 1ns/1ps
`default_nettype none

module cac_term_model #(
  parameter int ETU = 8
) (
  input  wire logic clock_i,
  input  wire logic io_oe_i,
  input  wire logic io_d_i,
  output logic      card_clk_o,
  output logic      card_rst_n_o,
  output logic      io_o
);
  logic [7:0] rx_q[$];
  logic [8:0] sh;
  logic       clk_en   = 1'b0;
  logic       clk_q    = 1'b0;
  logic       rst_n_q  = 1'b0;
  logic [4:0] term_cls = 5'h07;  // this terminal offers classes A, B and C
  int         par_err  = 0;
  int         cls_q    = 2;  // flag index; lowest voltage first, class C
  int         bad_q    = 0;
  logic       rejected = 1'b0;
  logic       no_cmd   = 1'b0;

  // ----------------------------------------
  // pins
  // ----------------------------------------
  assign io_o         = io_oe_i ? io_d_i : 1'b1;  // pull-up on a released line
  assign card_clk_o   = clk_q;
  assign card_rst_n_o = rst_n_q;
  always #200 if (clk_en) clk_q = ~clk_q;

  // class is settled while reset is held, before anything else
  task automatic activate();
    clk_en = 1'b1;
    repeat (20) @(posedge card_clk_o);
    @(posedge clock_i);
    rst_n_q <= 1'b1;
  endtask
  task automatic deactivate();
    @(posedge clock_i);
    rst_n_q <= 1'b0;
    clk_en = 1'b0;
  endtask
  // one class up in voltage, if offered; retries restart there
  task automatic step_up();
    if (cls_q > 0 && term_cls[cls_q - 1]) begin
      cls_q--;
      bad_q = 0;
    end else begin
      rejected = 1'b1;
    end
  endtask
  // silent card: power down, next try one class higher
  task automatic no_answer();
    deactivate();
    step_up();
  endtask
  // three bad answers per class, then only the next class
  task automatic note_bad();
    bad_q++;
    if (bad_q == 3) begin
      step_up();
    end
  endtask
  // class flags of the answer pick the next class or silence
  task automatic judge(input logic [4:0] flags);
    logic [4:0] both;
    both   = flags & term_cls;
    no_cmd = 1'b0;
    if (!flags[cls_q]) begin
      if (both == 5'h00) begin
        no_cmd = 1'b1;
      end else begin
        for (int i = 0; i < 5; i++) begin
          if (both[i]) begin
            cls_q = i;
          end
        end
        bad_q = 0;
      end
    end
  endtask

  // ----------------------------------------
  // receiver: any byte accepted, mid-bit sampling
  // ----------------------------------------
  always begin
    @(negedge io_o);
    #(ETU * 200);
    if (io_o === 1'b0) begin
      for (int i = 0; i < 9; i++) begin
        #(ETU * 400);
        sh[i] = io_o;
      end
      if (^sh !== 1'b0) par_err++;
      rx_q.push_back(sh[7:0]);
    end
  end
endmodule // cac_term_model

`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cac_consts.svh"

module tb;
  import cac_pkg::*;
  localparam int ETU = 8;
  logic      clock_i = 1'b0;
  logic      rst_n_i = 1'b0;
  cac_cfg_t  cfg;
  cac_byte_t tx = '0;
  logic      card_clk, card_rst_n, io_line, io_d, io_oe, tx_ready, atr_done, cfg_err;
  int        n_mismatch = 0;
  int        comparisons = 0;

  always #25 clock_i = ~clock_i;

  cac_term_model #(.ETU(ETU)) term_u (.clock_i(clock_i), .io_oe_i(io_oe), .io_d_i(io_d),
    .card_clk_o(card_clk), .card_rst_n_o(card_rst_n), .io_o(io_line));
  cac_card #(.ETU_CLKS(9'(ETU))) dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .card_clk_i(card_clk), .card_rst_n_i(card_rst_n), .io_i(io_line), .io_o(io_d),
    .io_oe_o(io_oe), .cfg_i(cfg), .tx_i(tx), .tx_ready_o(tx_ready),
    .atr_done_o(atr_done), .cfg_err_o(cfg_err));

  function automatic cac_cfg_t mk(input logic [4:0] cl, input logic [3:0] f,
                                  input logic [3:0] d);
    mk = '{classes: cl, fi: f, di: d, cds: 8'hA5, caps: 24'h12_3456};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic t_cfg_table();
    logic [13:0] tbl[7];
    tbl = '{{5'b00011, 4'h1, 4'h1, 1'b0}, {5'b00110, 4'h9, 4'h4, 1'b0},
            {5'b11000, 4'h9, 4'h7, 1'b0}, {5'b00101, 4'h9, 4'h5, 1'b1},
            {5'b00000, 4'h1, 4'h1, 1'b1}, {5'b00010, 4'h1, 4'h7, 1'b1},
            {5'b10000, 4'h9, 4'h6, 1'b1}};
    for (int i = 0; i < 7; i++) begin
      @(posedge clock_i);
      cfg <= mk(tbl[i][13:9], tbl[i][8:5], tbl[i][4:1]);
      repeat (6) @(posedge clock_i);
      #1;
      chk(cfg_err, tbl[i][0]);
    end
  endtask

  task automatic t_atr(input cac_cfg_t c, input logic err, input logic nc, input int cls);
    logic [7:0] e[14];
    logic       ok;
    int         k;
    ok = (c.fi == `CAC_FI_372 && c.di == `CAC_DI_1) || (c.fi == `CAC_FI_512 &&
         (c.di == `CAC_DI_8 || c.di == `CAC_DI_16 || c.di == `CAC_DI_64));
    e = '{`CAC_TS, `CAC_T0, ok ? {c.fi, c.di} : `CAC_TA1_DEF, `CAC_TD1, `CAC_TD2,
          {3'b000, c.classes}, 8'h80, 8'h31, c.cds, 8'h73, c.caps[23:16],
          c.caps[15:8], c.caps[7:0], 8'h00};
    for (k = 1; k < 13; k++) e[13] ^= e[k];
    term_u.deactivate();
    @(posedge clock_i);
    cfg <= c;
    term_u.activate();
    for (k = 0; k < 30000 && term_u.rx_q.size() < 14; k++) begin
      @(posedge clock_i);
      if (k == 9000) begin
        #1;
        chk(tx_ready, 1'b0);
      end
    end
    chk(term_u.rx_q.size(), 14);
    for (k = 0; k < 14 && k < term_u.rx_q.size(); k++) begin
      chk(term_u.rx_q[k], e[k]);
    end
    if (term_u.rx_q.size() > 5) begin
      term_u.judge(term_u.rx_q[5][4:0]);
    end
    chk(term_u.no_cmd, nc);
    chk(term_u.cls_q, cls);
    chk(term_u.rejected, 1'b0);
    for (k = 0; k < 400 && atr_done !== 1'b1; k++) @(posedge clock_i);
    #1;
    chk(atr_done, 1'b1);
    chk(cfg_err, err);
    term_u.rx_q.delete();
  endtask

  task automatic send(input logic [7:0] d);
    for (int k = 0; k < 2000 && tx_ready !== 1'b1; k++) begin
      @(posedge clock_i);
      #1;
    end
    @(posedge clock_i);
    tx <= '{valid: 1'b1, data: d};
    @(posedge clock_i);
    tx <= '{valid: 1'b0, data: d};
    #1;
    chk(tx_ready, 1'b0);
    chk(io_oe, 1'b1);
  endtask

  task automatic t_app();
    chk(term_u.no_cmd, 1'b0);
    send(8'hC3);
    send(8'h5A);
    for (int k = 0; k < 3000 && term_u.rx_q.size() < 2; k++) @(posedge clock_i);
    chk(term_u.rx_q.size(), 2);
    if (term_u.rx_q.size() == 2) begin
      chk(term_u.rx_q[0], 8'hC3);
      chk(term_u.rx_q[1], 8'h5A);
    end
    term_u.rx_q.delete();
  endtask

  // abort mid-answer: the line must be released and the answer left unfinished
  task automatic t_abort();
    term_u.deactivate();
    term_u.activate();
    for (int k = 0; k < 30000 && term_u.rx_q.size() < 3; k++) @(posedge clock_i);
    term_u.deactivate();
    term_u.note_bad();
    repeat (ETU * 8 * 12) @(posedge clock_i);
    #1;
    chk(io_oe, 1'b0);
    chk(atr_done, 1'b0);
    // a try cut off long before its answer counts as no answer
    term_u.activate();
    repeat (2000) @(posedge clock_i);
    #1;
    chk(io_oe, 1'b0);
    term_u.no_answer();
    chk(term_u.cls_q, 1);
    term_u.rx_q.delete();
  endtask

  task automatic test_done();
    $display("comparisons %0d n_mismatch %0d parity %0d", comparisons, n_mismatch,
             term_u.par_err);
    if (n_mismatch == 0 && comparisons > 0 && term_u.par_err == 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    cfg = mk(5'b00001, 4'h1, 4'h1);
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_cfg_table();
    t_atr(mk(5'b00110, 4'h9, 4'h5), 1'b0, 1'b0, 2);
    t_app();
    t_abort();
    t_atr(mk(5'b11000, 4'h1, 4'h7), 1'b1, 1'b1, 1);
    t_atr(mk(5'b00001, 4'h9, 4'h4), 1'b0, 1'b0, 0);
    test_done();
  end

  // ----------------------------------------
  // watchdog: all scenarios fit well inside
  // ----------------------------------------
  initial begin
    repeat (90000) @(posedge clock_i);
    n_mismatch++;
    test_done();
  end
endmodule // tb

`default_nettype wire
